// ==== dv/iao_core_model.sv ====
// Register file and slow exception handler facing the add unit
`timescale 1ns/1ps
`default_nettype none
module iao_core_model
	import iao_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [4:0]       rd_addr_a,
	input  wire logic [4:0]       rd_addr_b,
	output logic      [31:0]      rd_data_a,
	output logic      [31:0]      rd_data_b,
	input  wire iao_pkg::iao_wb_t wb,
	input  wire logic             exc,
	output logic                  exc_ack
);
	logic [31:0] regs [32];
	logic [1:0]  wait_reg;
	assign rd_data_a = regs[rd_addr_a];
	assign rd_data_b = regs[rd_addr_b];
	// Plain always: the bench preloads operands here too
	always @(posedge clk) begin
		if (wb.wr_en) regs[wb.wr_addr] <= wb.wr_data;
	end
	// Handler answers late so a hold-until-ack bug shows
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) wait_reg <= 2'h0;
		else wait_reg <= exc ? wait_reg + 2'h1 : 2'h0;
	end
	assign exc_ack = (wait_reg == 2'h3);
endmodule : iao_core_model
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the trapping add unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import iao_pkg::*;
	logic        clk, rst_n, instr_valid, exc_ack, instr_accept, sov, fv;
	logic [4:0]  ra, rb;
	logic [31:0] da, db, s;
	iao_instr_t  instr;
	iao_wb_t     wb;
	int          bad_count, cmp_count;
	logic [31:0] ea [4] = '{32'h7FFF_FFFF, 32'h8000_0000, 32'h7FFF_FFFF, 32'h4000_0000};
	logic [31:0] eb [4] = '{32'h0000_0001, 32'hFFFF_FFFF, 32'h8000_0000, 32'h4000_0000};
	iao_add_unit uut (.clk(clk), .rst_n(rst_n), .instr(instr), .instr_valid(instr_valid),
		.rd_addr_a(ra), .rd_addr_b(rb), .rd_data_a(da), .rd_data_b(db), .exc_ack(exc_ack),
		.instr_accept(instr_accept), .wb(wb), .signed_overflow_exception(sov),
		.field_violation(fv));
	iao_core_model p (.clk(clk), .rst_n(rst_n), .rd_addr_a(ra), .rd_addr_b(rb),
		.rd_data_a(da), .rd_data_b(db), .wb(wb), .exc(sov), .exc_ack(exc_ack));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic check(logic [31:0] seen, logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	function automatic logic ovf_of(logic [31:0] a, logic [31:0] b);
		logic [32:0] t;
		t = {a[31], a} + {b[31], b};
		return t[32] != t[31];
	endfunction : ovf_of
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	// Sources must differ so both preloads survive
	task automatic run(logic [5:0] op, logic [5:0] fn, logic [4:0] s1, logic [4:0] s2,
		logic [4:0] d, logic [4:0] un, logic [31:0] a, logic [31:0] b);
		logic go, trap;
		go = op == IAO_OPC_SPECIAL && (fn == IAO_FUNC_ADD_TRAP || fn == IAO_FUNC_ADD_NT);
		trap = go && fn == IAO_FUNC_ADD_TRAP && ovf_of(a, b);
		p.regs[s1] = a;
		p.regs[s2] = b;
		instr = {op, s1, s2, d, un, fn};
		instr_valid = 1'b1;
		@(posedge clk);
		// Valid stays up so adds also run back to back
		#1 check(sov, trap);
		check(wb.wr_en, go && !trap);
		if (go && !trap) check(wb.wr_addr, d);
		if (go && !trap) check(wb.wr_data, a + b);
		check(fv, go && un != 5'h00);
		check(ra, s1);
		check(rb, s2);
		if (trap) begin
			check(instr_accept, 1'b0);
			// Younger non-trapping add waits behind the trap
			instr.func = IAO_FUNC_ADD_NT;
			@(posedge clk);
			#1 check(wb.wr_en, 1'b0);
			repeat (2) @(posedge clk);
			#1 check(sov, 1'b1);
			check(wb.wr_en, 1'b0);
			@(posedge clk);
			#1 check(sov, 1'b0);
			check(instr_accept, 1'b1);
			check(wb.wr_en, 1'b0);
			// Preload again in case an older write hit a source
			p.regs[s1] = a;
			p.regs[s2] = b;
			@(posedge clk);
			#1 check(wb.wr_en, 1'b1);
			check(wb.wr_addr, d);
			check(wb.wr_data, a + b);
			check(sov, 1'b0);
		end
	endtask : run
	initial begin
		rst_n = 1'b0;
		instr_valid = 1'b0;
		instr = '0;
		bad_count = 0;
		cmp_count = 0;
		s = $urandom(45417);
		repeat (3) @(posedge clk);
		#1 rst_n = 1'b1;
		check(instr_accept, 1'b1);
		check(wb.wr_en, 1'b0);
		check(sov, 1'b0);
		check(fv, 1'b0);
		for (int i = 0; i < 8; i++) run(IAO_OPC_SPECIAL, i[0] ? IAO_FUNC_ADD_NT :
			IAO_FUNC_ADD_TRAP, 5'h03, 5'h04, 5'h05, 5'(i == 6), ea[i / 2], eb[i / 2]);
		run(6'h08, IAO_FUNC_ADD_TRAP, 5'h01, 5'h02, 5'h06, 5'h00,
			32'h0000_0001, 32'h0000_0002);
		run(IAO_OPC_SPECIAL, 6'h22, 5'h01, 5'h02, 5'h06, 5'h00,
			32'h0000_0001, 32'h0000_0002);
		repeat (60) begin
			s = $urandom;
			run(IAO_OPC_SPECIAL, 6'h20 + 6'(s[0]), s[5:1], ~s[5:1], s[10:6],
				s[11] ? s[16:12] : 5'h00, $urandom, $urandom);
		end
		print_verdict();
	end
	initial begin
		#20000;
		bad_count++;
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire

// ==== logic/iao_add_unit.sv ====
// Trapping/non-trapping integer add execution unit
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Sum second source plus first source, 32-bit
// - Trapping add overflow: no write, raise overflow exception
// - No overflow: write sum to destination
// - Overflow when sum bit 32 differs bit31
// - Non-trapping add always writes, never traps
// - Decode opcode/function; nonzero unused field flagged
module iao_add_unit
	import iao_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire iao_pkg::iao_instr_t    instr,
	input  wire logic                   instr_valid,
	output logic      [4:0]             rd_addr_a,
	output logic      [4:0]             rd_addr_b,
	input  wire logic [31:0]            rd_data_a,
	input  wire logic [31:0]            rd_data_b,
	input  wire logic                   exc_ack,
	output logic                        instr_accept,
	output iao_pkg::iao_wb_t            wb,
	output logic                        signed_overflow_exception,
	output logic                        field_violation
);
	import iao_pkg::*;

	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_TRAP = 2'b10
	} iao_state_t;

	iao_state_t  state_reg;
	iao_state_t  state_next;
	iao_req_t    req;
	logic [31:0] sum;
	logic        ovf;
	logic        is_add;
	logic        trap_now;

	function automatic logic is_add_form(input iao_instr_t i, input logic [5:0] f);
		is_add_form = (i.opcode == IAO_OPC_SPECIAL) && (i.func == f);
	endfunction : is_add_form

	assign rd_addr_a = instr.first_source_field;
	assign rd_addr_b = instr.second_source_field;

	// Holding in trap stops any younger instruction from reaching writeback
	assign instr_accept = (state_reg == ST_RUN);

	always_comb begin
		req              = '0;
		req.trapping     = is_add_form(instr, IAO_FUNC_ADD_TRAP);
		is_add           = req.trapping | is_add_form(instr, IAO_FUNC_ADD_NT);
		req.valid        = instr_valid & instr_accept & is_add;
		req.illegal_form = is_add & (instr.unused_field != IAO_ZERO_FIELD);
		req.dest_field   = instr.dest_field;
		req.opnd_a       = rd_data_a;
		req.opnd_b       = rd_data_b;
	end

	iao_adder u_adder (
		.opnd_a (req.opnd_b),
		.opnd_b (req.opnd_a),
		.sum    (sum),
		.ovf    (ovf)
	);

	// Only the trapping form may raise the exception
	assign trap_now = req.valid & req.trapping & ovf;

	// Trap state is left only on the core's acknowledge
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RUN: begin
				if (trap_now) begin
					state_next = ST_TRAP;
				end
			end
			ST_TRAP: begin
				if (exc_ack) begin
					state_next = ST_RUN;
				end
			end
			default: state_next = ST_RUN;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// Writeback register
	// Address and data hold when no add completes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb.wr_en   <= 1'b0;
			wb.wr_addr <= IAO_REG_RST;
			wb.wr_data <= IAO_DATA_RST;
		end else begin
			wb.wr_en <= req.valid & ~trap_now;
			if (req.valid & ~trap_now) begin
				wb.wr_addr <= req.dest_field;
				wb.wr_data <= sum;
			end
		end
	end

	// Exception stays up until the core acknowledges it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			signed_overflow_exception <= 1'b0;
		end else if (trap_now) begin
			signed_overflow_exception <= 1'b1;
		end else if (exc_ack) begin
			signed_overflow_exception <= 1'b0;
		end
	end

	// Unused field nonzero is unpredictable; we still execute, but report it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			field_violation <= 1'b0;
		end else begin
			field_violation <= req.valid & req.illegal_form;
		end
	end

	// Trap path: write suppressed, exception raised and held
	chk_ovf_no_write: assert property (@(posedge clk) disable iff (!rst_n)
		trap_now |=> !wb.wr_en && signed_overflow_exception)
		else $error("overflow did not suppress write");
	chk_exc_held: assert property (@(posedge clk) disable iff (!rst_n)
		(signed_overflow_exception && !exc_ack) |=> signed_overflow_exception)
		else $error("overflow exception dropped before acknowledge");
	chk_exc_cause: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(signed_overflow_exception) |-> $past(req.valid) && $past(req.trapping)
		&& ($past(rd_data_a[31]) == $past(rd_data_b[31]))
		&& ($past(sum[31]) != $past(rd_data_a[31])))
		else $error("overflow exception without signed overflow");
	chk_dest_kept: assert property (@(posedge clk) disable iff (!rst_n)
		!(req.valid && !trap_now) |=> $stable(wb.wr_addr) && $stable(wb.wr_data))
		else $error("writeback changed without a completed add");

	// Completed adds: sum, destination, non-trapping variant
	chk_sum_written: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && !trap_now) |=> wb.wr_en && wb.wr_data == $past(sum)
		&& wb.wr_addr == $past(req.dest_field))
		else $error("sum not written to destination");
	chk_invalid_ignored: assert property (@(posedge clk) disable iff (!rst_n)
		!instr_valid |=> !wb.wr_en)
		else $error("writeback without a valid instruction");
	chk_trapping_clean: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && req.trapping && !ovf) |=> wb.wr_en && !signed_overflow_exception)
		else $error("trapping add without overflow did not complete");
	chk_sum_value: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid |-> sum == rd_data_a + rd_data_b)
		else $error("sum wrong");
	chk_ovf_sign_rule: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid |-> ovf == ((rd_data_a[31] == rd_data_b[31]) && (sum[31] != rd_data_a[31])))
		else $error("overflow detection wrong");
	chk_nt_no_trap: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && !req.trapping) |=> wb.wr_en && !$rose(signed_overflow_exception))
		else $error("non-trapping add trapped");
	chk_nt_wraps: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && !req.trapping && ovf) |=> wb.wr_en
		&& wb.wr_data == $past(rd_data_a) + $past(rd_data_b))
		else $error("non-trapping add did not write the wrapped sum");

	// Decode and unused field
	chk_decode_form: assert property (@(posedge clk) disable iff (!rst_n)
		(instr_valid && instr.opcode != IAO_OPC_SPECIAL) |=> !wb.wr_en)
		else $error("non-add instruction executed");
	chk_func_ignored: assert property (@(posedge clk) disable iff (!rst_n)
		(instr_valid && instr.func != IAO_FUNC_ADD_TRAP && instr.func != IAO_FUNC_ADD_NT)
		|=> !wb.wr_en && !$rose(signed_overflow_exception))
		else $error("unknown function code executed");
	chk_field_flag: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && instr.unused_field != IAO_ZERO_FIELD) |=> field_violation)
		else $error("unused field violation not flagged");
	chk_no_false_flag: assert property (@(posedge clk) disable iff (!rst_n)
		!(req.valid && instr.unused_field != IAO_ZERO_FIELD) |=> !field_violation)
		else $error("field violation flagged without cause");
	chk_flag_executes: assert property (@(posedge clk) disable iff (!rst_n)
		field_violation |-> wb.wr_en || $rose(signed_overflow_exception))
		else $error("flagged add was not executed");

	// Precise trap: nothing younger is accepted or committed
	chk_precise_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(signed_overflow_exception && !exc_ack) |=> !wb.wr_en && !instr_accept)
		else $error("younger instruction committed during trap");
	chk_trap_blocks: assert property (@(posedge clk) disable iff (!rst_n)
		trap_now |=> !instr_accept)
		else $error("unit still accepting after a trap");
	chk_accept_tracks: assert property (@(posedge clk) disable iff (!rst_n)
		instr_accept == !signed_overflow_exception)
		else $error("accept does not follow the pending exception");
	chk_exc_release: assert property (@(posedge clk) disable iff (!rst_n)
		(signed_overflow_exception && exc_ack)
		|=> !signed_overflow_exception && instr_accept)
		else $error("trap not released after acknowledge");

	// Main scenarios
	cov_trap_add: cover property (@(posedge clk) disable iff (!rst_n) trap_now);
	cov_nt_overflow: cover property (@(posedge clk) disable iff (!rst_n)
		req.valid && !req.trapping && ovf);
	cov_back_to_back: cover property (@(posedge clk) disable iff (!rst_n)
		req.valid ##1 req.valid);
	cov_trap_ack: cover property (@(posedge clk) disable iff (!rst_n)
		signed_overflow_exception ##1 exc_ack ##1 req.valid);
	cov_field_flag: cover property (@(posedge clk) disable iff (!rst_n)
		req.valid && req.illegal_form);
endmodule : iao_add_unit
`default_nettype wire

// ==== logic/iao_adder.sv ====
// 33-bit sign-extended adder with overflow flag
`timescale 1ns/1ps
`default_nettype none
module iao_adder (
	input  wire logic [31:0] opnd_a,
	input  wire logic [31:0] opnd_b,
	output logic      [31:0] sum,
	output logic             ovf
);
	logic [32:0] wide_sum;

	always_comb begin
		wide_sum = {opnd_a[31], opnd_a} + {opnd_b[31], opnd_b};
		sum      = wide_sum[31:0];
		ovf      = wide_sum[32] ^ wide_sum[31];
	end
endmodule : iao_adder
`default_nettype wire

// ==== logic/iao_pkg.sv ====
// Package for the trapping integer add unit
`default_nettype none
package iao_pkg;
	localparam int          IAO_XLEN          = 32;
	localparam int          IAO_OPC_POS       = 26;
	localparam int          IAO_SRC1_POS      = 21;
	localparam int          IAO_SRC2_POS      = 16;
	localparam int          IAO_DST_POS       = 11;
	localparam int          IAO_SHAMT_POS     = 6;
	localparam int          IAO_FUNC_POS      = 0;
	localparam logic [5:0]  IAO_OPC_SPECIAL   = 6'h00;
	localparam logic [5:0]  IAO_FUNC_ADD_TRAP = 6'h20;
	localparam logic [5:0]  IAO_FUNC_ADD_NT   = 6'h21;
	localparam logic [4:0]  IAO_ZERO_FIELD    = 5'h00;
	localparam logic [31:0] IAO_DATA_RST      = 32'h0000_0000;
	localparam logic [4:0]  IAO_REG_RST       = 5'h00;

	typedef struct packed {
		logic [5:0] opcode;
		logic [4:0] first_source_field;
		logic [4:0] second_source_field;
		logic [4:0] dest_field;
		logic [4:0] unused_field;
		logic [5:0] func;
	} iao_instr_t;

	typedef struct packed {
		logic        valid;
		logic        trapping;
		logic        illegal_form;
		logic [4:0]  dest_field;
		logic [31:0] opnd_a;
		logic [31:0] opnd_b;
	} iao_req_t;

	typedef struct packed {
		logic        wr_en;
		logic [4:0]  wr_addr;
		logic [31:0] wr_data;
	} iao_wb_t;
endpackage : iao_pkg
`default_nettype wire
